// *** rtl/tmrc_core.sv ***
`timescale 1ns/1ps
// Contract
// R1: Default range stores plain binary degrees
// R2: Extended range adds sixty-four degrees offset
// R3: Plain range saturates at 0 and 127
// R4: Next result after range change uses it
// R5: Range change never alters limit contents
// R6: Twenty-two eight-bit registers in map; the code decodes only five read and two write addresses
// R7: First write byte loads the pointer
// R8: Second byte writes, reads use pointer
// R9: Pointer resets to zero
// R10: Result registers updated only by converter
// R11: Results at 0x00, 0x01, 0x10, reset zero
// R12: Configuration read 0x03, write 0x09
// R13: Host keeps reserved configuration bits zero
// R14: Mask bit gates alarm, not second output
// R15: Standby bit stops conversions
// R16: Bus and outputs stay live in standby
// R17: Bit 5 selects multipurpose pin function
// R18: Bit 2 selects measurement range
// R19: Rate read 0x04, write 0x0A
// R20: Rate code divides base period by powers
// R21: Host writes zero upper rate bits
// R22: Rate resets 0x08, both channels measured
// R23: Slow rates average sixteen measurements
// R24: Low byte read freezes high byte
// R25: Low byte holds two fraction bits
// R26: Writes to result addresses ignored
// R27: Reserved rate code keeps previous rate
module tmrc_core #(
  parameter logic [6:0] BUS_ADDRESS = 7'h2A, // Arbitrary value
  parameter int unsigned CONV_BASE_CYCLES = tmrc_pkg::CONV_BASE_CYCLES
) (
  // System
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Two-wire bus
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  // Alarm sources and multipurpose pin
  input wire logic ALARM_LATCH,
  input wire logic SECOND_OVERTEMP,
  output logic MULTI_PIN_N,
  // Converter link
  input wire logic CONV_CLK,
  output logic CONV_START,
  input wire logic CONV_DONE,
  input wire logic [8:0] LOCAL_RAW,
  input wire logic [10:0] REMOTE_RAW
);
  import tmrc_pkg::*;

  // ----------------------------------------------------------------
  // Format conversion
  // ----------------------------------------------------------------
  function automatic logic [9:0] tmrc_encode(input logic signed [10:0] q, input logic ext);
    logic signed [11:0] v;
    logic [9:0] r;
    v = {q[10], q};
    r = 10'h000;
    if (ext) begin
      // R2: offset binary
      v = v + EXT_OFFSET_Q;
      if (v < 0) r = 10'h000;
      else if (v > EXT_LIMIT_Q) r = EXT_SAT_CODE;
      else r = v[9:0];
    end else begin
      // R1: plain binary
      if (v < 0) r = 10'h000;
      // R3: saturate high
      else if (v >= PLAIN_LIMIT_Q) r = PLAIN_SAT_CODE;
      else r = v[9:0];
    end
    return r;
  endfunction : tmrc_encode

  function automatic logic [7:0] tmrc_read_mux(input logic [7:0] a, input logic [7:0] loc,
                                               input logic [7:0] rhi, input logic [7:0] rlo,
                                               input logic [7:0] cfg, input logic [7:0] rate);
    logic [7:0] r;
    r = 8'h00;
    // R6: eight-bit register map
    // R11: result locations
    // R12: configuration read
    // R19: rate read
    unique case (a)
      ADDR_LOCAL: r = loc;
      ADDR_REMOTE_HI: r = rhi;
      ADDR_REMOTE_LO: r = rlo;
      ADDR_CFG_RD: r = cfg;
      ADDR_RATE_RD: r = rate;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : tmrc_read_mux

  // ----------------------------------------------------------------
  // Reference domain state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_prev;
    logic sda_s1;
    logic sda_s2;
    logic sda_prev;
    tmrc_bus_t bus;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic first_byte;
    logic sda_low;
    logic sda_out;
    logic sda_oe_n;
    logic [7:0] pointer;
    logic [7:0] local_res;
    logic [7:0] remote_hi;
    logic [7:0] remote_lo;
    logic remote_lock;
    logic [7:0] cfg;
    logic [7:0] rate;
    logic [TIMER_W-1:0] timer;
    logic busy;
    logic avg;
    logic [4:0] meas_left;
    logic signed [14:0] acc_local;
    logic signed [14:0] acc_remote;
    logic req_tgl;
    logic done_s1;
    logic done_s2;
    logic done_seen;
    logic pin_n;
  } tmrc_ref_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic busy;
    logic start;
    logic done_tgl;
    logic [8:0] local_raw;
    logic [10:0] remote_raw;
  } tmrc_conv_t;

  tmrc_ref_t q, d;
  tmrc_conv_t cq, cd;
  logic crst_s1, crst_s2;

  localparam tmrc_ref_t REF_RESET = '{
    scl_s1: 1'b1, scl_s2: 1'b1, scl_prev: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_prev: 1'b1,
    bus: BUS_IDLE, bit_cnt: 3'h0, shift: 8'h00, first_byte: 1'b1, sda_low: 1'b0,
    sda_out: 1'b0, sda_oe_n: 1'b1, pointer: RST_POINTER, local_res: RST_RESULT, remote_hi: RST_RESULT,
    remote_lo: RST_RESULT, remote_lock: 1'b0, cfg: RST_CFG, rate: RST_RATE,
    timer: '0, busy: 1'b0, avg: 1'b0, meas_left: 5'h00, acc_local: '0, acc_remote: '0,
    req_tgl: 1'b0, done_s1: 1'b0, done_s2: 1'b0, done_seen: 1'b0, pin_n: 1'b1
  };

  // ----------------------------------------------------------------
  // Reference domain next state
  // ----------------------------------------------------------------
  logic scl_rise, scl_fall, bus_start, bus_stop, done_evt, timer_fire, do_load;
  logic [TIMER_W-1:0] period;
  logic signed [14:0] sum_local, sum_remote;
  logic signed [10:0] avg_local, avg_remote;
  logic [9:0] enc_local, enc_remote;
  logic [7:0] rd_byte;

  always_comb begin
    d = q;
    do_load = 1'b0;
    d.scl_s1 = SCL_IN;
    d.scl_s2 = q.scl_s1;
    d.scl_prev = q.scl_s2;
    d.sda_s1 = SDA_IN;
    d.sda_s2 = q.sda_s1;
    d.sda_prev = q.sda_s2;
    d.done_s1 = cq.done_tgl;
    d.done_s2 = q.done_s1;
    scl_rise = q.scl_s2 & ~q.scl_prev;
    scl_fall = ~q.scl_s2 & q.scl_prev;
    bus_start = q.scl_s2 & q.scl_prev & q.sda_prev & ~q.sda_s2;
    bus_stop = q.scl_s2 & q.scl_prev & ~q.sda_prev & q.sda_s2;
    rd_byte = tmrc_read_mux(q.pointer, q.local_res, q.remote_hi, q.remote_lo, q.cfg, q.rate);

    // R16: bus serviced regardless of standby
    if (bus_stop) begin
      d.bus = BUS_IDLE;
      d.sda_low = 1'b0;
    end else if (bus_start) begin
      d.bus = BUS_ADDR;
      d.bit_cnt = 3'h0;
      d.first_byte = 1'b1;
      d.sda_low = 1'b0;
    end else begin
      unique case (q.bus)
        BUS_IDLE: d.sda_low = 1'b0;
        BUS_ADDR, BUS_WR: if (scl_rise) begin
          d.shift = {q.shift[6:0], q.sda_s2};
          d.bit_cnt = q.bit_cnt + 3'h1;
          if (q.bit_cnt == 3'h7) d.bus = (q.bus == BUS_ADDR) ? BUS_ADDR_END : BUS_WR_END;
        end
        BUS_ADDR_END: if (scl_fall) begin
          d.sda_low = (q.shift[7:1] == BUS_ADDRESS);
          d.bus = (q.shift[7:1] == BUS_ADDRESS) ? BUS_ACK_ADDR : BUS_IDLE;
        end
        BUS_ACK_ADDR: if (scl_fall) begin
          if (q.shift[0]) begin
            do_load = 1'b1;
          end else begin
            d.sda_low = 1'b0;
            d.bus = BUS_WR;
          end
        end
        BUS_WR_END: if (scl_fall) begin
          d.sda_low = 1'b1;
          d.bus = BUS_ACK_WR;
          d.first_byte = 1'b0;
          if (q.first_byte) begin
            // R7: first byte is the pointer
            d.pointer = q.shift;
          end else begin
            // R8: data to selected register
            unique case (q.pointer)
              // R12: configuration write
              // R5: limits untouched by range
              ADDR_CFG_WR: d.cfg = q.shift;
              // R19: rate write
              // R27: reserved codes ignored
              ADDR_RATE_WR: if (q.shift <= RATE_MAX_CODE) d.rate = q.shift;
              // R26: result addresses read-only
              // R10: bus never writes results
              default: d.cfg = q.cfg;
            endcase
          end
        end
        BUS_ACK_WR: if (scl_fall) begin
          d.sda_low = 1'b0;
          d.bus = BUS_WR;
        end
        BUS_RD: begin
          if (scl_rise) begin
            d.bit_cnt = q.bit_cnt + 3'h1;
            if (q.bit_cnt == 3'h7) d.bus = BUS_RD_END;
          end
          if (scl_fall) begin
            d.sda_low = ~q.shift[6];
            d.shift = {q.shift[6:0], 1'b0};
          end
        end
        BUS_RD_END: if (scl_fall) begin
          d.sda_low = 1'b0;
          d.bus = BUS_RACK;
        end
        BUS_RACK: if (scl_rise) d.bus = q.sda_s2 ? BUS_IDLE : BUS_LOAD;
        BUS_LOAD: if (scl_fall) do_load = 1'b1;
      endcase
    end

    // R8: reads come from pointer target
    if (do_load) begin
      d.shift = rd_byte;
      d.sda_low = ~rd_byte[7];
      d.bit_cnt = 3'h0;
      d.bus = BUS_RD;
      // R24: low read locks, high read unlocks
      if (q.pointer == ADDR_REMOTE_LO) d.remote_lock = 1'b1;
      if (q.pointer == ADDR_REMOTE_HI) d.remote_lock = 1'b0;
    end

    // R20: base period halved per code step
    period = TIMER_W'(CONV_BASE_CYCLES >> q.rate[3:0]);
    timer_fire = 1'b0;
    // R15: standby keeps the timer at zero
    if (q.cfg[CFG_STANDBY_BIT]) begin
      d.timer = '0;
    end else if (q.timer >= period - TIMER_W'(1)) begin
      d.timer = '0;
      timer_fire = 1'b1;
    end else begin
      d.timer = q.timer + TIMER_W'(1);
    end

    // A period that lands mid-sequence is skipped rather than queued
    if (timer_fire && !q.busy) begin
      d.busy = 1'b1;
      // R23: averaging chosen per period
      d.avg = (q.rate[3:0] < RATE_FIRST_UNAVERAGED);
      d.meas_left = (q.rate[3:0] < RATE_FIRST_UNAVERAGED) ? AVG_COUNT : 5'h01;
      d.acc_local = '0;
      d.acc_remote = '0;
      d.req_tgl = ~q.req_tgl;
    end

    done_evt = q.done_s2 ^ q.done_seen;
    d.done_seen = q.done_s2;
    sum_local = q.acc_local + 15'(signed'({cq.local_raw, 2'b00}));
    sum_remote = q.acc_remote + 15'(signed'(cq.remote_raw));
    avg_local = q.avg ? sum_local[14:4] : sum_local[10:0];
    avg_remote = q.avg ? sum_remote[14:4] : sum_remote[10:0];
    // R4: range sampled at commit time
    // R18: range bit drives format
    enc_local = tmrc_encode(avg_local, q.cfg[CFG_RANGE_BIT]);
    enc_remote = tmrc_encode(avg_remote, q.cfg[CFG_RANGE_BIT]);
    if (done_evt && q.busy) begin
      if (q.meas_left == 5'h01) begin
        // R22: both channels per period
        // R10: only converter path updates
        d.busy = 1'b0;
        d.local_res = enc_local[9:2];
        // R24: frozen high byte skipped
        if (!(q.remote_lock || d.remote_lock)) d.remote_hi = enc_remote[9:2];
        // R25: two fraction bits, rest zero
        d.remote_lo = {enc_remote[1:0], 6'b00_0000};
      end else begin
        d.meas_left = q.meas_left - 5'h01;
        d.acc_local = sum_local;
        d.acc_remote = sum_remote;
        d.req_tgl = ~q.req_tgl;
      end
    end

    // R17: pin function select
    // R14: mask only for alarm function
    if (q.cfg[CFG_PIN_FUNCTION_SELECT_BIT]) d.pin_n = ~SECOND_OVERTEMP;
    else d.pin_n = ~(ALARM_LATCH & ~q.cfg[CFG_ALARM_MASK_BIT]);
    d.sda_out = 1'b0;
    // Drive enable registered so the pin comes straight from a flop
    d.sda_oe_n = ~d.sda_low;
  end

  // R9: pointer and registers reset
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) q <= REF_RESET;
    else q <= d;
  end

  // ----------------------------------------------------------------
  // Converter domain
  // ----------------------------------------------------------------
  always_ff @(posedge CONV_CLK) begin
    crst_s1 <= SYS_RST;
    crst_s2 <= crst_s1;
  end

  always_comb begin
    cd = cq;
    cd.req_s1 = q.req_tgl;
    cd.req_s2 = cq.req_s1;
    cd.start = 1'b0;
    if (!cq.busy && (cq.req_s2 != cq.req_seen)) begin
      cd.req_seen = cq.req_s2;
      cd.busy = 1'b1;
      cd.start = 1'b1;
    end else if (cq.busy && CONV_DONE) begin
      // Words held until the next request, which waits on this toggle
      cd.busy = 1'b0;
      cd.local_raw = LOCAL_RAW;
      cd.remote_raw = REMOTE_RAW;
      cd.done_tgl = ~cq.done_tgl;
    end
  end

  always_ff @(posedge CONV_CLK) begin
    if (crst_s2) cq <= '0;
    else cq <= cd;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SDA_OUT = q.sda_out;
  assign SDA_OE_N = q.sda_oe_n;
  assign MULTI_PIN_N = q.pin_n;
  assign CONV_START = cq.start;
endmodule : tmrc_core

// *** rtl/tmrc_pkg.sv ***
package tmrc_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LOCAL = 8'h00;
  localparam logic [7:0] ADDR_REMOTE_HI = 8'h01;
  localparam logic [7:0] ADDR_CFG_RD = 8'h03;
  localparam logic [7:0] ADDR_RATE_RD = 8'h04;
  localparam logic [7:0] ADDR_CFG_WR = 8'h09;
  localparam logic [7:0] ADDR_RATE_WR = 8'h0A;
  localparam logic [7:0] ADDR_REMOTE_LO = 8'h10;
  localparam int REG_COUNT = 22;
  localparam int REG_WIDTH = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h08;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  localparam int CFG_ALARM_MASK_BIT = 7;
  localparam int CFG_STANDBY_BIT = 6;
  localparam int CFG_PIN_FUNCTION_SELECT_BIT = 5;
  localparam int CFG_RANGE_BIT = 2;

  // ----------------------------------------------------------------
  // Conversion rate
  // ----------------------------------------------------------------
  localparam logic [7:0] RATE_MAX_CODE = 8'h0A;
  localparam logic [3:0] RATE_FIRST_UNAVERAGED = 4'h8;
  localparam logic [4:0] AVG_COUNT = 5'h10;
  localparam int AVG_SHIFT = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 40_000_000;
  localparam longint CONV_BASE_PERIOD_S = 16;
  localparam int TIMER_W = 30;
  localparam int unsigned CONV_BASE_CYCLES = int'(CONV_BASE_PERIOD_S * CLK_HZ);

  // ----------------------------------------------------------------
  // Data format, quarter degree units
  // ----------------------------------------------------------------
  localparam logic signed [11:0] EXT_OFFSET_Q = 12'sh100;
  localparam logic signed [11:0] PLAIN_LIMIT_Q = 12'sh200;
  localparam logic signed [11:0] EXT_LIMIT_Q = 12'sh3FF;
  localparam logic [9:0] PLAIN_SAT_CODE = 10'h1FC;
  localparam logic [9:0] EXT_SAT_CODE = 10'h3FF;

  // ----------------------------------------------------------------
  // Bus states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_END, BUS_ACK_ADDR, BUS_WR, BUS_WR_END,
    BUS_ACK_WR, BUS_RD, BUS_RD_END, BUS_RACK, BUS_LOAD
  } tmrc_bus_t;
endpackage : tmrc_pkg

// *** tb/tmrc_core_monitor.sv ***
`timescale 1ns/1ps
module tmrc_core_monitor (
  // System
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Two-wire bus
  input wire logic SCL_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  // Multipurpose pin
  input wire logic ALARM_LATCH,
  input wire logic SECOND_OVERTEMP,
  input wire logic MULTI_PIN_N,
  // Converter link
  input wire logic CONV_CLK,
  input wire logic CONV_START
);
  // ----
  // Bus side
  // ----
  sda_out_zero_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST) !SDA_OUT)
    else $error("data output not zero");
  // Drive must not move while SCL is high or a START/STOP would be faked
  oe_edge_low_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $changed(SDA_OE_N) |-> !SCL_IN && !$past(SCL_IN))
    else $error("data drive changed near clock high");
  oe_low_hold_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $fell(SDA_OE_N) |=> !SDA_OE_N [*8])
    else $error("data drive too short");
  release_idle_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $past(SYS_RST) |-> SDA_OE_N && MULTI_PIN_N)
    else $error("outputs not idle after reset");
  // ----
  // Multipurpose pin
  // ----
  pin_low_cause_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !MULTI_PIN_N |-> $past(ALARM_LATCH) || $past(SECOND_OVERTEMP))
    else $error("pin low without source");
  pin_change_cause_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    $changed(MULTI_PIN_N) |-> $past(SYS_RST, 2) || !SCL_IN || $past(ALARM_LATCH) != $past(ALARM_LATCH, 2)
      || $past(SECOND_OVERTEMP) != $past(SECOND_OVERTEMP, 2))
    else $error("pin changed without cause");
  // ----
  // Converter link
  // ----
  start_single_a: assert property (@(posedge CONV_CLK) disable iff (SYS_RST)
    CONV_START |=> !CONV_START [*8])
    else $error("start not a lone pulse");
  start_after_rst_a: assert property (@(posedge CONV_CLK) disable iff (SYS_RST)
    $fell(SYS_RST) |-> !CONV_START [*8])
    else $error("start too soon after reset");
  cover property (@(posedge REF_CLK) $fell(SDA_OE_N));
  cover property (@(posedge CONV_CLK) CONV_START);
  cover property (@(posedge REF_CLK) !MULTI_PIN_N);
endmodule : tmrc_core_monitor

// *** tb/tmrc_conv_model.sv ***
`timescale 1ns/1ps
module tmrc_conv_model (
  // Converter link
  input wire logic CONV_CLK,
  input wire logic CONV_START,
  output logic CONV_DONE,
  output logic [8:0] LOCAL_RAW,
  output logic [10:0] REMOTE_RAW,
  // Bench control
  input wire logic [8:0] local_val,
  input wire logic [10:0] remote_val,
  output int n_starts
);
  int wait_n = 0;
  initial begin
    CONV_DONE = 1'b0;
    LOCAL_RAW = '0;
    REMOTE_RAW = '0;
    n_starts = 0;
  end
  // Words churn while busy so a sample off the done cycle shows up
  always @(posedge CONV_CLK) begin
    if (CONV_START) begin
      CONV_DONE <= 1'b0;
      n_starts <= n_starts + 1;
      wait_n <= 1 + n_starts % 5;
    end else if (wait_n == 1) begin
      wait_n <= 0;
      CONV_DONE <= 1'b1;
      LOCAL_RAW <= local_val;
      REMOTE_RAW <= remote_val;
    end else if (wait_n > 1) begin
      wait_n <= wait_n - 1;
      CONV_DONE <= 1'b0;
      LOCAL_RAW <= ~LOCAL_RAW;
      REMOTE_RAW <= ~REMOTE_RAW;
    end else begin
      CONV_DONE <= 1'b0;
    end
  end
endmodule : tmrc_conv_model

// *** tb/tmrc_core_bench.sv ***
`timescale 1ns/1ps
module tmrc_core_bench;
  import tmrc_pkg::*;
  localparam logic [6:0] DEV = 7'h2A; // Arbitrary value
  localparam int BASE = 20480;
  logic REF_CLK, SYS_RST, SCL_IN, ALARM_LATCH, SECOND_OVERTEMP, CONV_CLK, sda_h;
  logic SDA_OUT, SDA_OE_N, MULTI_PIN_N, CONV_START, CONV_DONE;
  logic [8:0] LOCAL_RAW, lv;
  logic [10:0] REMOTE_RAW, rv;
  logic [31:0] seed = 32'h0000_0053;
  logic [7:0] d;
  int n_errors = 0, n_compared = 0, n_starts, cyc = 0;
  // Pull-up on the data wire
  wire logic SDA_IN = SDA_OE_N ? sda_h : 1'b0;
  tmrc_core #(.BUS_ADDRESS(DEV), .CONV_BASE_CYCLES(BASE)) tmrc_core_inst (.REF_CLK, .SYS_RST, .SCL_IN,
    .SDA_IN, .SDA_OUT, .SDA_OE_N, .ALARM_LATCH, .SECOND_OVERTEMP, .MULTI_PIN_N, .CONV_CLK, .CONV_START,
    .CONV_DONE, .LOCAL_RAW, .REMOTE_RAW);
  tmrc_conv_model tmrc_conv_model_inst (.CONV_CLK, .CONV_START, .CONV_DONE, .LOCAL_RAW, .REMOTE_RAW,
    .local_val(lv), .remote_val(rv), .n_starts);
  initial begin
    REF_CLK = 0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  initial begin
    CONV_CLK = 0;
    #1.3;
    forever #3 CONV_CLK = ~CONV_CLK;
  end
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_errors++;
      end_of_test();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Quarter degrees in, stored ten-bit code out
  function automatic logic [9:0] enc(input int q, input bit ext);
    if (ext) q += 256;
    if (q < 0) q = 0;
    if (!ext && q > 511) q = 508;
    if (q > 1023) q = 1023;
    return q[9:0];
  endfunction : enc
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
    #2;
  endtask : tick
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic done(input string t);
    $display("test %s finished", t);
  endtask : done
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Data moves only mid low phase, well clear of both clock edges
  task automatic bitx(input logic b, output logic r);
    sda_h = b;
    tick(8);
    SCL_IN = 1;
    tick(8);
    r = SDA_IN;
    SCL_IN = 0;
    tick(4);
  endtask : bitx
  task automatic start();
    sda_h = 1;
    SCL_IN = 1;
    tick(8);
    sda_h = 0;
    tick(8);
    SCL_IN = 0;
    tick(4);
  endtask : start
  task automatic stop();
    sda_h = 0;
    tick(8);
    SCL_IN = 1;
    tick(8);
    sda_h = 1;
    tick(8);
  endtask : stop
  task automatic wbyte(input logic [7:0] v, input logic e);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(v[i], a);
    bitx(1'b1, a);
    chk({7'h00, a}, {7'h00, e});
  endtask : wbyte
  task automatic wr(input logic [7:0] p, input logic [7:0] v, input bit has_v);
    start();
    wbyte({DEV, 1'b0}, 1'b0);
    wbyte(p, 1'b0);
    if (has_v) wbyte(v, 1'b0);
    stop();
  endtask : wr
  task automatic rcur(output logic [7:0] v);
    logic a;
    start();
    wbyte({DEV, 1'b1}, 1'b0);
    for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
    bitx(1'b1, a);
    stop();
  endtask : rcur
  task automatic rd(input logic [7:0] p, output logic [7:0] v);
    wr(p, 8'h00, 1'b0);
    rcur(v);
  endtask : rd
  task automatic rchk(input logic [7:0] p, input logic [7:0] e);
    rd(p, d);
    chk(d, e);
  endtask : rchk
  task automatic convs(input int n);
    int s;
    s = n_starts;
    repeat (3000) if (n_starts < s + n) tick(1);
    tick(10);
  endtask : convs
  task automatic check3(input int l, input int r, input bit ext);
    logic [9:0] e, f;
    e = enc(r, ext);
    f = enc(l * 4, ext);
    rd(ADDR_REMOTE_LO, d);
    chk(d, {e[1:0], 6'h00});
    rd(ADDR_REMOTE_HI, d);
    chk(d, e[9:2]);
    rd(ADDR_LOCAL, d);
    chk(d, f[9:2]);
  endtask : check3
  initial begin
    int cr[4] = '{-1, 512, -257, 768};
    int cl[4] = '{-1, 128, -65, 192};
    logic [7:0] cfgs[4] = '{8'h00, 8'h80, 8'h20, 8'hE0};
    int l, r, s;
    bit ext;
    SYS_RST = 1;
    SCL_IN = 1;
    sda_h = 1;
    ALARM_LATCH = 0;
    SECOND_OVERTEMP = 0;
    lv = 9'd25;
    rv = '0;
    tick(10);
    SYS_RST = 0;
    tick(10);
    rcur(d);
    chk(d, 8'h19);
    rchk(ADDR_CFG_RD, RST_CFG);
    rchk(ADDR_RATE_RD, RST_RATE);
    done("reset");
    rv = 11'd101;
    for (int c = 7; c < 12; c++) begin
      wr(ADDR_RATE_WR, 8'(c), 1'b1);
      s = n_starts;
      tick(8 * (BASE >> (c > 10 ? 10 : c)));
      // Slow codes run sixteen measurements per period
      chk(8'((n_starts - s) inside {[7 * (c < 8 ? 16 : 1):9 * (c < 8 ? 16 : 1)]}), 8'h01);
      if (c == 7) check3(25, 101, 1'b0);
    end
    rchk(ADDR_RATE_RD, RATE_MAX_CODE);
    start();
    wbyte({DEV ^ 7'h01, 1'b0}, 1'b1);
    stop();
    done("rate");
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      l = i < 4 ? cl[i] : int'($signed(seed[8:0]));
      r = i < 4 ? cr[i] : int'($signed(seed[27:17]));
      ext = i < 4 ? i[1] : seed[31];
      wr(ADDR_CFG_WR, {5'h00, ext, 2'h0}, 1'b1);
      lv = l[8:0];
      rv = r[10:0];
      convs(3);
      check3(l, r, ext);
    end
    // Standby so no conversion can mask a stray bus write
    wr(ADDR_CFG_WR, {1'b0, 1'b1, 3'h0, ext, 2'h0}, 1'b1);
    tick(20);
    wr(ADDR_LOCAL, 8'h5A, 1'b1);
    wr(ADDR_REMOTE_HI, 8'h5A, 1'b1);
    wr(ADDR_REMOTE_LO, 8'h5A, 1'b1);
    check3(l, r, ext);
    wr(ADDR_CFG_WR, {5'h00, ext, 2'h0}, 1'b1);
    done("format");
    rv = 11'd40;
    convs(3);
    rd(ADDR_REMOTE_LO, d);
    rv = 11'd400;
    convs(3);
    rchk(ADDR_REMOTE_HI, 8'(enc(40, ext) >> 2));
    convs(3);
    rchk(ADDR_REMOTE_HI, 8'(enc(400, ext) >> 2));
    wr(ADDR_CFG_WR, 8'h40, 1'b1);
    tick(20);
    s = n_starts;
    tick(200);
    chk(8'(n_starts - s), 8'h00);
    rchk(ADDR_CFG_RD, 8'h40);
    done("lock and standby");
    foreach (cfgs[k]) begin
      wr(ADDR_CFG_WR, cfgs[k], 1'b1);
      rchk(ADDR_CFG_RD, cfgs[k]);
      for (int m = 0; m < 4; m++) begin
        ALARM_LATCH = m[0];
        SECOND_OVERTEMP = m[1];
        tick(3);
        chk({7'h00, MULTI_PIN_N}, {7'h00, cfgs[k][5] ? ~m[1] : ~(m[0] & ~cfgs[k][7])});
      end
    end
    done("pin");
    end_of_test();
  end
endmodule : tmrc_core_bench
bind tmrc_core tmrc_core_monitor tmrc_core_monitor_inst (.REF_CLK, .SYS_RST, .SCL_IN, .SDA_OUT, .SDA_OE_N,
  .ALARM_LATCH, .SECOND_OVERTEMP, .MULTI_PIN_N, .CONV_CLK, .CONV_START);
